// File: logic/adcsc_defs.vh
`ifndef ADCSC_DEFS_VH
`define ADCSC_DEFS_VH
// register indices; all are word aligned, so each byte address is four times its index
`define ADCSC_IDX_SCR        6'h3C
`define ADCSC_IDX_RES        6'h3E
`define ADCSC_IDX_CLK        6'h3F
`define ADCSC_ADDR_SCR       8'hF0
`define ADCSC_ADDR_RES       8'hF8
`define ADCSC_ADDR_CLK       8'hFC
`define ADCSC_ADDR_IRQ_STAT  8'h40
`define ADCSC_ADDR_IRQ_MASK  8'h44
// status/control fields
`define ADCSC_SCR_DONE_BIT   7
`define ADCSC_SCR_IEN_BIT    6
`define ADCSC_SCR_REP_BIT    5
`define ADCSC_SCR_CH_MSB     4
`define ADCSC_SCR_RESET      5'h1F
`define ADCSC_CLK_MSB        7
`define ADCSC_CLK_LSB        5
`define ADCSC_CLK_RESET      3'h0
// conversion timing
`define ADCSC_CONV_CLOCKS    16
`define ADCSC_NUM_CH         4
// axi responses
`define ADCSC_RESP_OKAY      2'h0
`define ADCSC_RESP_SLVERR    2'h2
`endif

// File: logic/adcsc_chan_mux.v
`timescale 1ns/100ps
// one-hot routing of the selected channel onto the converter input
module adcsc_chan_mux #(
  parameter NUM_CH = 4
) (
  input  wire              clk_sys_i,
  input  wire              rst_i,
  input  wire [4:0]        sel_i,
  input  wire              active_i,
  output reg  [NUM_CH-1:0] route_o
);
  genvar g;
  // at most one switch closed; out-of-range codes connect nothing
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_sw
      always @(posedge clk_sys_i) begin
        if (rst_i) begin
          route_o[g] <= 1'b0;
        end else begin
          route_o[g] <= active_i && (sel_i == g);
        end
      end
    end
  endgenerate
endmodule // adcsc_chan_mux

// File: logic/adcsc_conv_seq.v
`timescale 1ns/100ps
`include "adcsc_defs.vh"
// conversion sequencer: divided clock ticks, start, abort, result capture
module adcsc_conv_seq #(
  parameter CONV_CLOCKS = `ADCSC_CONV_CLOCKS
) (
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire [2:0] div_sel_i,
  input  wire       start_i,
  input  wire       abort_i,
  input  wire       repeat_i,
  input  wire [7:0] sample_i,
  output reg        busy_o,
  output reg        done_o,
  output reg  [7:0] data_o
);
  reg [6:0] pre_r;
  reg [4:0] cnt_r;
  reg       tick_r;
  wire [6:0] pre_top = (7'h01 << div_sel_i) - 7'h01;

  // prescaler: converter clock is bus clock over 2^div_sel
  always @(posedge clk_sys_i) begin
    if (rst_i || !busy_o) begin
      pre_r  <= 7'h00;
      tick_r <= 1'b0;
    end else if (pre_r >= pre_top) begin
      pre_r  <= 7'h00;
      tick_r <= 1'b1;
    end else begin
      pre_r  <= pre_r + 7'h01;
      tick_r <= 1'b0;
    end
  end

  // abort drops the run with no result; done pulses once per conversion
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      cnt_r  <= 5'h00;
      data_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        busy_o <= 1'b0;
        cnt_r  <= 5'h00;
      end else if (start_i) begin
        busy_o <= 1'b1;
        cnt_r  <= 5'h00;
      end else if (busy_o && tick_r) begin
        if (cnt_r == CONV_CLOCKS[4:0] - 5'h01) begin
          data_o <= sample_i;
          done_o <= 1'b1;
          cnt_r  <= 5'h00;
          busy_o <= repeat_i;
        end else begin
          cnt_r <= cnt_r + 5'h01;
        end
      end
    end
  end
endmodule // adcsc_conv_seq

// File: logic/adcsc_top.v
// What this block does
// - stop entry halts the converter and drops a running conversion with no result, flagged in status bit1.
// - leaving stop restarts conversions with the stored settings, no rewrite needed.
// - four analogue channels on port A pins, picked by channel select.
// - at most one selected channel is routed to the converter; none when out of range.
// - status/control: done bit7, irq enable bit6, repeat bit5, channel 4..0.
// - result register shows the latest conversion; no reset value promised.
// - clock register holds divider in bits 7..5; low bits read zero.
// - done flag sets per conversion unless irq enable; cleared by result read.
`timescale 1ns/100ps
`include "adcsc_defs.vh"
module adcsc_top #(
  parameter NUM_CH      = `ADCSC_NUM_CH,
  parameter CONV_CLOCKS = `ADCSC_CONV_CLOCKS
) (
  input  wire              clk_sys_i,
  input  wire              rst_i,
  // axi4-lite slave
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // system and converter side
  input  wire              stop_mode_i,
  input  wire [7:0]        sample_i,
  output wire [NUM_CH-1:0] selected_analog_input_o,
  output reg  [NUM_CH-1:0] port_a_analog_o,
  output reg               conv_active_o,
  output reg               irq_o
);
  // synchronised stop request and sample bus (from analogue/power domain)
  reg        stop_s1_r, stop_s2_r;
  reg  [7:0] smp_s1_r, smp_s2_r;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      stop_s1_r <= 1'b0;
      stop_s2_r <= 1'b0;
      smp_s1_r  <= 8'h00;
      smp_s2_r  <= 8'h00;
    end else begin
      stop_s1_r <= stop_mode_i;
      stop_s2_r <= stop_s1_r;
      smp_s1_r  <= sample_i;
      smp_s2_r  <= smp_s1_r;
    end
  end

  // register state
  reg        irq_en_r, rep_r;
  reg  [4:0] chan_r;
  reg  [2:0] div_r;
  reg        done_flag_r;
  reg  [7:0] result_r;
  reg  [1:0] ist_r, imask_r;
  reg        stop_d_r;
  reg        restart_r;

  wire       busy_w, cdone_w;
  wire [7:0] cdata_w;

  // axi write path: address and data taken in either order
  reg        aw_have_r, w_have_r;
  reg  [7:0] aw_addr_r;
  reg  [31:0] w_data_r;
  reg  [3:0] w_strb_r;
  wire       wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  wire       wr_scr = wr_go && aw_addr_r == `ADCSC_ADDR_SCR && w_strb_r[0];
  wire       wr_clk = wr_go && aw_addr_r == `ADCSC_ADDR_CLK && w_strb_r[0];
  wire       wr_msk = wr_go && aw_addr_r == `ADCSC_ADDR_IRQ_MASK && w_strb_r[0];
  wire       wr_hit = aw_addr_r == `ADCSC_ADDR_SCR || aw_addr_r == `ADCSC_ADDR_CLK
                   || aw_addr_r == `ADCSC_ADDR_IRQ_MASK || aw_addr_r == `ADCSC_ADDR_RES
                   || aw_addr_r == `ADCSC_ADDR_IRQ_STAT;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADCSC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `ADCSC_RESP_OKAY : `ADCSC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read path
  wire       rd_go  = s_axi_arvalid && s_axi_arready;
  wire       rd_res = rd_go && s_axi_araddr == `ADCSC_ADDR_RES;
  wire       rd_ist = rd_go && s_axi_araddr == `ADCSC_ADDR_IRQ_STAT;
  reg  [7:0] rd_byte;
  reg        rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `ADCSC_ADDR_SCR:      rd_byte = {done_flag_r && !irq_en_r, irq_en_r, rep_r, chan_r};
      `ADCSC_ADDR_RES:      rd_byte = result_r;
      `ADCSC_ADDR_CLK:      rd_byte = {div_r, 5'h00};
      `ADCSC_ADDR_IRQ_STAT: rd_byte = {6'h00, ist_r};
      `ADCSC_ADDR_IRQ_MASK: rd_byte = {6'h00, imask_r};
      default: begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ADCSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_hit ? `ADCSC_RESP_OKAY : `ADCSC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control registers; bit 7 of the write is ignored since done is read-only
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_en_r <= 1'b0;
      rep_r    <= 1'b0;
      chan_r   <= `ADCSC_SCR_RESET;
      div_r    <= `ADCSC_CLK_RESET;
      imask_r  <= 2'h0;
    end else begin
      if (wr_scr) begin
        irq_en_r <= w_data_r[`ADCSC_SCR_IEN_BIT];
        rep_r    <= w_data_r[`ADCSC_SCR_REP_BIT];
        chan_r   <= w_data_r[`ADCSC_SCR_CH_MSB:0];
      end
      if (wr_clk)
        div_r <= w_data_r[`ADCSC_CLK_MSB:`ADCSC_CLK_LSB];
      if (wr_msk)
        imask_r <= w_data_r[1:0];
    end
  end

  // stop handling: remember to restart once stop is released
  wire stop_exit = stop_d_r && !stop_s2_r;
  wire chan_ok   = chan_r < NUM_CH;
  wire abort_w   = stop_s2_r || wr_scr;
  wire start_w   = (restart_r && chan_ok) || (wr_scr && chan_ok);
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      stop_d_r  <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      stop_d_r  <= stop_s2_r;
      // resume one cycle after the abort clears, with settings unchanged
      restart_r <= stop_exit || (wr_scr && !stop_s2_r);
    end
  end

  adcsc_conv_seq #(
    .CONV_CLOCKS (CONV_CLOCKS)
  ) u_seq (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .div_sel_i (div_r),
    .start_i   (start_w && !stop_s2_r),
    .abort_i   (abort_w),
    .repeat_i  (rep_r),
    .sample_i  (smp_s2_r),
    .busy_o    (busy_w),
    .done_o    (cdone_w),
    .data_o    (cdata_w)
  );

  adcsc_chan_mux #(
    .NUM_CH (NUM_CH)
  ) u_mux (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .sel_i     (chan_r),
    .active_i  (!stop_s2_r),
    .route_o   (selected_analog_input_o)
  );

  // done flag and result: set wins over clear by result read
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      done_flag_r <= 1'b0;
      result_r    <= 8'h00;
    end else begin
      if (cdone_w)
        result_r <= cdata_w;
      if (cdone_w && !irq_en_r)
        done_flag_r <= 1'b1;
      else if (rd_res || irq_en_r)
        done_flag_r <= 1'b0;
    end
  end

  // sticky status: bit0 conversion done, bit1 stop abort; read clears, set wins
  wire [1:0] ev_w = {stop_s2_r && busy_w, cdone_w};
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ist_r <= 2'h0;
    end else begin
      ist_r <= ev_w | (rd_ist ? 2'h0 : ist_r);
    end
  end

  // outputs registered so the pins never see decode glitches
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_o         <= 1'b0;
      conv_active_o <= 1'b0;
    end else begin
      irq_o         <= |(ist_r & imask_r) || (irq_en_r && cdone_w && imask_r[0]);
      conv_active_o <= busy_w;
    end
  end

  // one pin-mode flop per channel; out-of-range selects leave every pin digital
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_pin
      always @(posedge clk_sys_i) begin
        if (rst_i) begin
          port_a_analog_o[g] <= 1'b0;
        end else begin
          port_a_analog_o[g] <= (chan_r == g);
        end
      end
    end
  endgenerate
endmodule // adcsc_top

// File: verification/adcsc_properties.sv
`timescale 1ns/100ps
// watches routing, stop and bus handshakes at the pins
module adcsc_props #(
  parameter NUM_CH = 4
) (
  input wire              clk_sys_i,
  input wire              rst_i,
  input wire              stop_mode_i,
  input wire [NUM_CH-1:0] selected_analog_input_o,
  input wire [NUM_CH-1:0] port_a_analog_o,
  input wire              conv_active_o,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // routing: never two pads on the converter at once
  a_mux_one_hot: assert property ($onehot0(selected_analog_input_o))
    else $error("two channels routed");
  a_port_one_hot: assert property ($onehot0(port_a_analog_o))
    else $error("two port pins claimed");
  // stop goes through two sync flops, then the mux output register or the busy and conv_active_o registers
  a_stop_mux_off: assert property (stop_mode_i [*6] |-> selected_analog_input_o == 0)
    else $error("channel routed in stop");
  a_stop_idle: assert property (stop_mode_i [*6] |-> !conv_active_o)
    else $error("converting in stop");
  // bus: ready answers a request, answers drop once taken
  a_aw_cause: assert property (s_axi_awready |-> $past(s_axi_awvalid) ##1 !s_axi_awready)
    else $error("address ready unasked");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer held");
endmodule // adcsc_props

bind adcsc_top adcsc_props #(.NUM_CH(NUM_CH)) i_props (.clk_sys_i, .rst_i, .stop_mode_i,
  .selected_analog_input_o, .port_a_analog_o, .conv_active_o, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// File: verification/adcsc_core_model.sv
`timescale 1ns/100ps
// converter core stand-in: routed channel k reads 8'hA5 ^ k
module adcsc_core_model #(
  parameter NUM_CH = 4
) (
  input  wire              clk_sys_i,
  input  wire [NUM_CH-1:0] route_i,
  output reg  [7:0]        sample_o
);
  integer   k;
  reg [7:0] sample_nxt;
  initial sample_o = 8'h00;
  // unrouted input toggles so a stale code never passes for a result
  always @(posedge clk_sys_i) begin
    sample_nxt = ~sample_o;
    for (k = 0; k < NUM_CH; k = k + 1)
      if (route_i[k]) sample_nxt = 8'hA5 ^ k[7:0];
    sample_o <= sample_nxt;
  end
endmodule // adcsc_core_model

// File: verification/tb_adc_control_and_stop_handling.sv
`timescale 1ns/100ps
`include "adcsc_defs.vh"
// bus-level test of the converter control block
module tb_adc_control_and_stop_handling;
  reg          clk_sys_i, rst_i, stop_mode_i, s_axi_awvalid, s_axi_wvalid;
  reg          s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg   [7:0]  s_axi_awaddr, s_axi_araddr;
  reg   [31:0] s_axi_wdata;
  reg   [3:0]  s_axi_wstrb;
  reg   [1:0]  rsp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         conv_active_o, irq_o;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [7:0]  sample_i;
  wire  [3:0]  selected_analog_input_o, port_a_analog_o;
  integer      fails, samples_checked, ch;
  adcsc_top #(.NUM_CH(4), .CONV_CLOCKS(16)) i_dut (.clk_sys_i, .rst_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode_i, .sample_i,
    .selected_analog_input_o, .port_a_analog_o, .conv_active_o, .irq_o);
  adcsc_core_model #(.NUM_CH(4)) i_core (.clk_sys_i, .route_i(selected_analog_input_o),
    .sample_o(sample_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // a used-up wait is a mismatch and ends the run
  task wait_ok(input integer n);
    begin
      chk(n < 300, 1);
      if (n >= 300)
        test_done;
    end
  endtask
  // address and data offered together, each dropped once taken
  task axi_wr(input [7:0] a, input [31:0] d);
    integer n;
    reg     aw, w;
    begin
      @(posedge clk_sys_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {aw, w, n} = 0;
      while (s_axi_bvalid !== 1'b1 && n < 300) begin
        @(posedge clk_sys_i);
        n = n + 1;
        aw = aw | s_axi_awready;
        w = w | s_axi_wready;
        s_axi_awvalid <= !aw;
        s_axi_wvalid <= !w;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      wait_ok(n);
    end
  endtask
  task axi_rd(input [7:0] a, input [31:0] exp);
    integer n;
    begin
      @(posedge clk_sys_i);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      n = 0;
      while (s_axi_rvalid !== 1'b1 && n < 300) begin
        @(posedge clk_sys_i);
        n = n + 1;
        if (s_axi_arready === 1'b1)
          s_axi_arvalid <= 1'b0;
      end
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      wait_ok(n);
      chk(s_axi_rdata, exp);
    end
  endtask
  task wait_irq;
    integer n;
    begin
      n = 0;
      while (irq_o !== 1'b1 && n < 300) begin
        @(posedge clk_sys_i);
        n = n + 1;
      end
      wait_ok(n);
    end
  endtask
  // main sequence; status/control writes keep the done bit zero
  initial begin
    fails = 0;
    samples_checked = 0;
    {rst_i, stop_mode_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h10;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    axi_rd(`ADCSC_ADDR_SCR, 32'h1F);
    axi_rd(`ADCSC_ADDR_CLK, 32'h00);
    axi_wr(`ADCSC_ADDR_CLK, 32'hFF);
    axi_rd(`ADCSC_ADDR_CLK, 32'hE0);
    axi_wr(`ADCSC_ADDR_CLK, 32'h20);
    axi_wr(8'h80, 32'h1);
    chk(rsp, `ADCSC_RESP_SLVERR);
    axi_rd(8'h80, 32'h0);
    chk(rsp, `ADCSC_RESP_SLVERR);
    axi_wr(`ADCSC_ADDR_IRQ_MASK, 32'h1);
    chk(rsp, `ADCSC_RESP_OKAY);
    // channel 3 is cut short by channel 0 and must not report
    axi_wr(`ADCSC_ADDR_SCR, 32'h03);
    for (ch = 0; ch < 4; ch = ch + 1) begin
      axi_wr(`ADCSC_ADDR_SCR, ch);
      wait_irq;
      axi_rd(`ADCSC_ADDR_IRQ_STAT, 32'h1);
      axi_rd(`ADCSC_ADDR_SCR, 32'h80 | ch);
      chk(port_a_analog_o, 4'h1 << ch);
      axi_rd(`ADCSC_ADDR_RES, 32'hA5 ^ ch);
      axi_rd(`ADCSC_ADDR_SCR, ch);
      chk(irq_o, 1'b0);
    end
    axi_wr(`ADCSC_ADDR_SCR, 32'h41);
    wait_irq;
    axi_rd(`ADCSC_ADDR_SCR, 32'h41);
    axi_rd(`ADCSC_ADDR_IRQ_STAT, 32'h1);
    // repeat mode on channel 2, then stop in mid-conversion
    axi_wr(`ADCSC_ADDR_SCR, 32'h22);
    wait_irq;
    stop_mode_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk({conv_active_o, selected_analog_input_o}, 5'h0);
    axi_rd(`ADCSC_ADDR_IRQ_STAT, 32'h3);
    repeat (100) @(posedge clk_sys_i);
    chk(irq_o, 1'b0);
    stop_mode_i <= 1'b0;
    wait_irq;
    chk(selected_analog_input_o, 4'h4);
    axi_rd(`ADCSC_ADDR_IRQ_STAT, 32'h1);
    // irq still shows the cleared status for one edge; let it fall first
    @(posedge clk_sys_i);
    chk(irq_o, 1'b0);
    wait_irq;
    axi_rd(`ADCSC_ADDR_RES, 32'hA7);
    // masked events keep the line low
    axi_wr(`ADCSC_ADDR_IRQ_MASK, 32'h0);
    axi_rd(`ADCSC_ADDR_IRQ_MASK, 32'h0);
    repeat (100) @(posedge clk_sys_i);
    chk(irq_o, 1'b0);
    // an out-of-range channel halts conversions and releases every pin
    axi_wr(`ADCSC_ADDR_SCR, 32'h1F);
    repeat (4) @(posedge clk_sys_i);
    chk({conv_active_o, selected_analog_input_o, port_a_analog_o}, 9'h000);
    test_done;
  end
endmodule // tb_adc_control_and_stop_handling
